// ===== src/slpus_pkg.sv
package slpus_pkg;

  // ****************************************
  // Word format
  // ****************************************
  localparam int WORD_W = 24;
  localparam logic [1:0] CTL_REF = 2'h0;
  localparam logic [1:0] CTL_DIV = 2'h1;
  localparam logic [1:0] CTL_FUNC = 2'h2;
  localparam logic [1:0] CTL_INIT = 2'h3;
  localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CNT_RST = 2;
  localparam int BIT_PD1 = 3;
  localparam int BIT_MUX_LO = 4;
  localparam int MUX_W = 3;
  localparam int BIT_PD2 = 21;
  localparam int BIT_RESYNC_EN = 21;
  localparam int BIT_RESYNC_DLY = 22;

  // ****************************************
  // Monitor output selections
  // ****************************************
  localparam logic [2:0] MON_LOW = 3'h0;
  localparam logic [2:0] MON_LOCK = 3'h1;
  localparam logic [2:0] MON_DIV = 3'h2;
  localparam logic [2:0] MON_HIGH = 3'h3;
  localparam logic [2:0] MON_REF = 3'h4;
  localparam logic [2:0] MON_LOCK_OD = 3'h5;
  localparam logic [2:0] MON_SERIAL_DATA_PIN = 3'h6;
  localparam logic [2:0] MON_GND = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_TIME_US = 1;
  localparam int SETTLE_CYC = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 8;
  localparam int LE_HIGH_CYC = 8;
  localparam int TMR_W = 9;
  localparam int BITCNT_W = 5;

  typedef enum logic [2:0] {
    SLPUS_IDLE,
    SLPUS_LO,
    SLPUS_HI,
    SLPUS_STROBE
  } slpus_host_state_t;

  // Rising edge between an older and a newer sample
  function automatic logic slpus_rise(input logic older, input logic newer);
    return newer & ~older;
  endfunction

endpackage

// ===== src/slpus_link_if.sv
`timescale 1ns/10ps
interface slpus_link_if;
  logic serial_clock_pin;
  logic serial_data_pin;
  logic latch_strobe_pin;
  logic power_enable_pin;
  logic monitor_output_pin;

  modport dev (
    input serial_clock_pin,
    input serial_data_pin,
    input latch_strobe_pin,
    input power_enable_pin,
    output monitor_output_pin
  );

  modport host (
    output serial_clock_pin,
    output serial_data_pin,
    output latch_strobe_pin,
    output power_enable_pin,
    input monitor_output_pin
  );
endinterface

// ===== src/slpus_dev.sv
`timescale 1ns/10ps
// Behaviour
// - Code 11 init latch, 10 function latch
// - Code 00 loads reference counter latch
// - Code 01 loads divider A/B latch
// - Init word carries counter reset zero
// - Init write also updates function latch
// - Init pulse resets counters, tristates pump
// - Pulse leaves prescaler reference, buffer running; with PD1 and PD2 both set it starts synchronous power-down
// - First divider load after init repulses
// - Power enable low powers down immediately
// - Latches loadable while down; rise realigns
// - Host flags settled 1 us after enable rise
// - Latches retained across power enable cycles
// - Counter reset method: set, load, clear
// - Counter reset holds, no synchronous power-down
// - Reference latch: delay bit 22, enable 21
// - Resync enable retimes prescaler to RF
// - Delay select retimes to delayed RF
// - Monitor pin selects internal signal, lock
// - 24-bit shift on sclk; strobe transfers
// - Function bit 2 holds counters reset
// - Input register active during power-down
module slpus_dev
  import slpus_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  slpus_link_if.dev link,
  input wire logic rf_in_in,
  input wire logic prescaler_raw_in,
  input wire logic lock_indication_in,
  input wire logic div_event_in,
  input wire logic ref_event_in,
  input wire logic cp_event_in,
  output logic [WORD_W-1:0] ref_latch_out,
  output logic [WORD_W-1:0] div_latch_out,
  output logic [WORD_W-1:0] func_latch_out,
  output logic counter_hold_out,
  output logic cp_tristate_out,
  output logic powered_down_out,
  output logic bias_on_out,
  output logic reset_pulse_out,
  output logic prescaler_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sclk_s;
  logic [1:0] sdat_s;
  logic [2:0] le_s;
  logic [1:0] ce_s;
  logic [3:0] rf_s;
  logic [1:0] pre_s;
  logic [2:0] cp_s;
  logic [1:0] lock_s;
  logic [1:0] div_s;
  logic [1:0] ref_s;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sclk_s <= 3'h0;
      sdat_s <= 2'h0;
      le_s <= 3'h0;
      ce_s <= 2'h0;
      rf_s <= 4'h0;
      pre_s <= 2'h0;
      cp_s <= 3'h0;
      lock_s <= 2'h0;
      div_s <= 2'h0;
      ref_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.serial_clock_pin};
      sdat_s <= {sdat_s[0], link.serial_data_pin};
      le_s <= {le_s[1:0], link.latch_strobe_pin};
      ce_s <= {ce_s[0], link.power_enable_pin};
      rf_s <= {rf_s[2:0], rf_in_in};
      pre_s <= {pre_s[0], prescaler_raw_in};
      cp_s <= {cp_s[1:0], cp_event_in};
      lock_s <= {lock_s[0], lock_indication_in};
      div_s <= {div_s[0], div_event_in};
      ref_s <= {ref_s[0], ref_event_in};
    end
  end

  logic sclk_rise;
  logic le_rise;
  logic rf_edge;
  logic rf_edge_dly;
  logic cp_edge;
  assign sclk_rise = slpus_rise(sclk_s[2], sclk_s[1]);
  assign le_rise = slpus_rise(le_s[2], le_s[1]);
  assign rf_edge = slpus_rise(rf_s[2], rf_s[1]);
  assign rf_edge_dly = slpus_rise(rf_s[3], rf_s[2]);
  assign cp_edge = slpus_rise(cp_s[2], cp_s[1]);

  // ****************************************
  // Input shift register
  // ****************************************
  // Never gated by power-down, so words can be loaded while disabled
  logic [WORD_W-1:0] shreg;
  logic [1:0] wsel;
  assign wsel = shreg[1:0];

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      shreg <= LATCH_RST;
    end else if (sclk_rise) begin
      shreg <= {shreg[WORD_W-2:0], sdat_s[1]};
    end
  end

  // ****************************************
  // Latches
  // ****************************************
  // Only the chip reset clears them; power enable cycles keep contents
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ref_latch_out <= LATCH_RST;
      div_latch_out <= LATCH_RST;
      func_latch_out <= LATCH_RST;
    end else if (le_rise) begin
      case (wsel)
        CTL_REF: begin
          ref_latch_out <= shreg;
        end
        CTL_DIV: begin
          div_latch_out <= shreg;
        end
        CTL_FUNC: begin
          func_latch_out <= shreg;
        end
        CTL_INIT: begin
          func_latch_out <= shreg;
        end
        default: begin
          func_latch_out <= func_latch_out;
        end
      endcase
    end
  end

  // ****************************************
  // Internal reset pulse
  // ****************************************
  logic pulse_armed;
  logic next_pulse;
  assign next_pulse = le_rise & ((wsel == CTL_INIT) | ((wsel == CTL_DIV) & pulse_armed));

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pulse_armed <= 1'b0;
    end else if (le_rise && wsel == CTL_INIT) begin
      pulse_armed <= 1'b1;
    end else if (le_rise && wsel == CTL_DIV) begin
      pulse_armed <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      reset_pulse_out <= 1'b0;
    end else begin
      reset_pulse_out <= next_pulse;
    end
  end

  // ****************************************
  // Power-down
  // ****************************************
  // Counter reset bit is not a term here: it must not start power-down
  logic soft_pd;
  logic pd1;
  logic pd2;
  logic next_pd;
  logic next_hold;
  assign pd1 = func_latch_out[BIT_PD1];
  assign pd2 = func_latch_out[BIT_PD2];
  assign next_pd = ~ce_s[1] | soft_pd;
  assign next_hold = next_pd | next_pulse | func_latch_out[BIT_CNT_RST];

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      soft_pd <= 1'b0;
    end else if (!pd1) begin
      soft_pd <= 1'b0;
    end else if (!pd2) begin
      soft_pd <= 1'b1;
    end else if (cp_edge || reset_pulse_out) begin
      soft_pd <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      powered_down_out <= 1'b1;
      bias_on_out <= 1'b0;
    end else begin
      powered_down_out <= next_pd;
      bias_on_out <= ~next_pd;
    end
  end

  // Hold and pump release together when enable rises: close alignment
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      counter_hold_out <= 1'b1;
      cp_tristate_out <= 1'b1;
    end else begin
      counter_hold_out <= next_hold;
      cp_tristate_out <= next_hold;
    end
  end

  // ****************************************
  // Prescaler resynchronisation
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      prescaler_out <= 1'b0;
    end else if (!ref_latch_out[BIT_RESYNC_EN]) begin
      prescaler_out <= pre_s[1];
    end else if (ref_latch_out[BIT_RESYNC_DLY] ? rf_edge_dly : rf_edge) begin
      prescaler_out <= pre_s[1];
    end
  end

  // ****************************************
  // Monitor output
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      link.monitor_output_pin <= 1'b0;
    end else begin
      case (func_latch_out[BIT_MUX_LO +: MUX_W])
        MON_LOW: begin
          link.monitor_output_pin <= 1'b0;
        end
        MON_LOCK: begin
          link.monitor_output_pin <= lock_s[1];
        end
        MON_DIV: begin
          link.monitor_output_pin <= div_s[1];
        end
        MON_HIGH: begin
          link.monitor_output_pin <= 1'b1;
        end
        MON_REF: begin
          link.monitor_output_pin <= ref_s[1];
        end
        MON_LOCK_OD: begin
          link.monitor_output_pin <= lock_s[1];
        end
        MON_SERIAL_DATA_PIN: begin
          link.monitor_output_pin <= sdat_s[1];
        end
        MON_GND: begin
          link.monitor_output_pin <= 1'b0;
        end
        default: begin
          link.monitor_output_pin <= 1'b0;
        end
      endcase
    end
  end

endmodule // slpus_dev

// ===== src/slpus_host.sv
`timescale 1ns/10ps
module slpus_host
  import slpus_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  slpus_link_if.host link,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic word_valid_in,
  output logic word_ready_out,
  input wire logic power_enable_in,
  output logic settled_out,
  output logic lock_out
);

  // ****************************************
  // Serial sequencer
  // ****************************************
  slpus_host_state_t state;
  logic [WORD_W-1:0] sh;
  logic [BITCNT_W-1:0] bitcnt;
  logic [TMR_W-1:0] tmr;
  logic [WORD_W-1:0] next_word;

  // Init words always go out with counter reset cleared
  always_comb begin
    next_word = word_in;
    if (word_in[1:0] == CTL_INIT) begin
      next_word[BIT_CNT_RST] = 1'b0;
    end
  end

  // Sequencing of words is left to the user side
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state <= SLPUS_IDLE;
      sh <= LATCH_RST;
      bitcnt <= '0;
      tmr <= '0;
      word_ready_out <= 1'b0;
      link.serial_clock_pin <= 1'b0;
      link.serial_data_pin <= 1'b0;
      link.latch_strobe_pin <= 1'b0;
    end else begin
      case (state)
        SLPUS_IDLE: begin
          word_ready_out <= 1'b1;
          if (word_valid_in && word_ready_out) begin
            word_ready_out <= 1'b0;
            sh <= next_word;
            link.serial_data_pin <= next_word[WORD_W-1];
            bitcnt <= BITCNT_W'(WORD_W - 1);
            tmr <= TMR_W'(SCLK_HALF_CYC - 1);
            state <= SLPUS_LO;
          end
        end
        SLPUS_LO: begin
          if (tmr == '0) begin
            link.serial_clock_pin <= 1'b1;
            tmr <= TMR_W'(SCLK_HALF_CYC - 1);
            state <= SLPUS_HI;
          end else begin
            tmr <= tmr - 1'b1;
          end
        end
        SLPUS_HI: begin
          if (tmr != '0) begin
            tmr <= tmr - 1'b1;
          end else if (bitcnt == '0) begin
            link.serial_clock_pin <= 1'b0;
            link.latch_strobe_pin <= 1'b1;
            tmr <= TMR_W'(LE_HIGH_CYC - 1);
            state <= SLPUS_STROBE;
          end else begin
            link.serial_clock_pin <= 1'b0;
            link.serial_data_pin <= sh[WORD_W-2];
            sh <= {sh[WORD_W-2:0], 1'b0};
            bitcnt <= bitcnt - 1'b1;
            tmr <= TMR_W'(SCLK_HALF_CYC - 1);
            state <= SLPUS_LO;
          end
        end
        SLPUS_STROBE: begin
          if (tmr == '0) begin
            link.latch_strobe_pin <= 1'b0;
            state <= SLPUS_IDLE;
          end else begin
            tmr <= tmr - 1'b1;
          end
        end
        default: begin
          state <= SLPUS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Power enable and settling
  // ****************************************
  logic [TMR_W-1:0] settle_cnt;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      link.power_enable_pin <= 1'b0;
      settle_cnt <= '0;
      settled_out <= 1'b0;
    end else begin
      link.power_enable_pin <= power_enable_in;
      if (!link.power_enable_pin) begin
        settle_cnt <= TMR_W'(SETTLE_CYC - 1);
        settled_out <= 1'b0;
      end else if (settle_cnt != '0) begin
        settle_cnt <= settle_cnt - 1'b1;
      end else begin
        settled_out <= 1'b1;
      end
    end
  end

  // ****************************************
  // Monitor input
  // ****************************************
  logic [1:0] mon_s;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mon_s <= 2'h0;
      lock_out <= 1'b0;
    end else begin
      mon_s <= {mon_s[0], link.monitor_output_pin};
      lock_out <= mon_s[1];
    end
  end

endmodule // slpus_host

// ===== verif/slpus_link_props.sv
`timescale 1ns/10ps
module slpus_link_props (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic latch_strobe_pin,
  input wire logic power_enable_pin,
  input wire logic monitor_output_pin
);
  // ****************************************
  // Clock rises per frame
  // ****************************************
  logic [5:0] rise_cnt;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || latch_strobe_pin) begin
      rise_cnt <= 6'h00;
    end else if ($rose(serial_clock_pin)) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end

  // ****************************************
  // Wire properties
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  strobe_width_a: assert property (
    $rose(latch_strobe_pin) |-> latch_strobe_pin [*8] ##1 !latch_strobe_pin)
    else $error("strobe width wrong");
  sclk_high_a: assert property (
    $rose(serial_clock_pin) |-> serial_clock_pin [*8] ##1 !serial_clock_pin)
    else $error("serial clock high phase wrong");
  sclk_low_a: assert property (
    $fell(serial_clock_pin) |-> !serial_clock_pin [*8])
    else $error("serial clock low phase short");
  data_hold_a: assert property (
    serial_clock_pin |-> $stable(serial_data_pin))
    else $error("data moved while clock high");
  data_setup_a: assert property (
    $rose(serial_clock_pin) |-> serial_data_pin == $past(serial_data_pin, 4))
    else $error("data setup too short");
  strobe_edge_a: assert property (
    $rose(latch_strobe_pin) |-> $fell(serial_clock_pin))
    else $error("strobe not after last bit");
  strobe_quiet_a: assert property (
    latch_strobe_pin |-> !serial_clock_pin)
    else $error("clock active during strobe");
  bit_count_a: assert property (
    $rose(latch_strobe_pin) |-> rise_cnt == 6'h18)
    else $error("frame bit count wrong");

  power_cycle_c: cover property ($fell(power_enable_pin));
  monitor_high_c: cover property ($rose(monitor_output_pin));
endmodule // slpus_link_props

// ===== verif/synth_latch_power_up_sequencer_test.sv
`timescale 1ns/10ps
module synth_latch_power_up_sequencer_test
  import slpus_pkg::*;
();
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [WORD_W-1:0] word_in = 24'h000000;
  logic word_valid_in = 1'b0;
  logic power_enable_in = 1'b0;
  logic rf_in_in = 1'b0;
  logic prescaler_raw_in = 1'b0;
  logic lock_indication_in = 1'b0;
  logic div_event_in = 1'b0;
  logic ref_event_in = 1'b0;
  logic word_ready_out, settled_out, lock_out;
  logic [WORD_W-1:0] ref_latch_out, div_latch_out, func_latch_out;
  logic counter_hold_out, cp_tristate_out, powered_down_out;
  logic bias_on_out, reset_pulse_out, prescaler_out;
  int err_count = 0;
  int compares = 0;
  int pulses = 0;
  int hold_cnt = 0;
  logic bias_bad = 1'b0;

  always #2 mclk_in = ~mclk_in;
  always @(negedge mclk_in) rf_in_in <= ~rf_in_in;
  always @(negedge mclk_in) prescaler_raw_in <= rf_in_in;

  // ****************************************
  // Structure
  // ****************************************
  slpus_link_if i_slpus_link_if();
  slpus_host i_slpus_host (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(i_slpus_link_if),
    .word_in(word_in), .word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
    .power_enable_in(power_enable_in), .settled_out(settled_out), .lock_out(lock_out));
  // Pump events held idle, so only a reset pulse could start synchronous power-down
  slpus_dev i_slpus_dev (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(i_slpus_link_if),
    .rf_in_in(rf_in_in), .prescaler_raw_in(prescaler_raw_in),
    .lock_indication_in(lock_indication_in), .div_event_in(div_event_in),
    .ref_event_in(ref_event_in),
    .cp_event_in(1'b0), .ref_latch_out(ref_latch_out), .div_latch_out(div_latch_out),
    .func_latch_out(func_latch_out), .counter_hold_out(counter_hold_out),
    .cp_tristate_out(cp_tristate_out), .powered_down_out(powered_down_out),
    .bias_on_out(bias_on_out), .reset_pulse_out(reset_pulse_out),
    .prescaler_out(prescaler_out));
  slpus_link_props i_slpus_link_props (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .serial_clock_pin(i_slpus_link_if.serial_clock_pin),
    .serial_data_pin(i_slpus_link_if.serial_data_pin),
    .latch_strobe_pin(i_slpus_link_if.latch_strobe_pin),
    .power_enable_pin(i_slpus_link_if.power_enable_pin),
    .monitor_output_pin(i_slpus_link_if.monitor_output_pin));

  always @(posedge mclk_in) begin
    if (reset_pulse_out === 1'b1) begin
      pulses <= pulses + 1;
      if (bias_on_out !== 1'b1) bias_bad <= 1'b1;
      // Counted only with a pulse: reset alone also holds the counters
      if (counter_hold_out === 1'b1 && cp_tristate_out === 1'b1) hold_cnt <= hold_cnt + 1;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic conclude();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [WORD_W-1:0] seen,
                     input logic [WORD_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (word_ready_out !== 1'b1) begin
      @(negedge mclk_in);
      n++;
      if (n > 1000) begin
        err_count++;
        conclude();
      end
    end
  endtask

  // Returns once the frame is over, so the latch has long been loaded
  task automatic send(input logic [WORD_W-1:0] w);
    wait_ready();
    word_in = w;
    word_valid_in = 1'b1;
    @(negedge mclk_in);
    word_valid_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    wait_ready();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init();
    send(24'h000017);
    chk("func", func_latch_out, 24'h000013);
    chk("pulses", 24'(pulses), 24'h000001);
    chk("held", 24'(hold_cnt), 24'h000001);
    send(24'h600100);
    chk("ref", ref_latch_out, 24'h600100);
    chk("pulses", 24'(pulses), 24'h000001);
    send(24'h012345);
    chk("div", div_latch_out, 24'h012345);
    chk("pulses", 24'(pulses), 24'h000002);
    chk("held", 24'(hold_cnt), 24'h000002);
    send(24'h0abc01);
    chk("pulses", 24'(pulses), 24'h000002);
    chk("bias", 24'(bias_bad), 24'h000000);
    chk("hold", 24'(counter_hold_out), 24'h000000);
  endtask

  task automatic t_monitor();
    logic [2:0] sel [9] = '{MON_LOCK, MON_LOCK, MON_HIGH, MON_LOW, MON_LOCK_OD, MON_GND,
                            MON_DIV, MON_REF, MON_SERIAL_DATA_PIN};
    logic lk [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic ev [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic ex [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 9; i++) begin
      lock_indication_in = lk[i];
      // Opposite levels on the two events tell a swapped selection apart
      div_event_in = ev[i];
      ref_event_in = !ev[i];
      send({17'h00000, sel[i], 2'h0, CTL_FUNC});
      chk("func", func_latch_out, {17'h00000, sel[i], 2'h0, CTL_FUNC});
      // Two sync chains and output flops lie between input and lock_out
      repeat (12) @(negedge mclk_in);
      chk("lock", 24'(lock_out), 24'(ex[i]));
    end
  endtask

  task automatic t_power();
    power_enable_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    chk("pd", 24'(powered_down_out), 24'h000001);
    chk("cp", 24'(cp_tristate_out), 24'h000001);
    chk("bias", 24'(bias_on_out), 24'h000000);
    send(24'h000012);
    send(24'h000500);
    send(24'h000401);
    chk("func", func_latch_out, 24'h000012);
    chk("ref", ref_latch_out, 24'h000500);
    chk("div", div_latch_out, 24'h000401);
    power_enable_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    chk("pd", 24'(powered_down_out), 24'h000000);
    chk("hold", 24'(counter_hold_out), 24'h000000);
    chk("ref", ref_latch_out, 24'h000500);
    chk("div", div_latch_out, 24'h000401);
    chk("settled", 24'(settled_out), 24'h000000);
    repeat (SETTLE_CYC + 8) @(negedge mclk_in);
    chk("settled", 24'(settled_out), 24'h000001);
  endtask

  task automatic t_cnt_reset();
    // Synchronous power-down armed as well: counter reset alone must not start it
    send(24'h20001e);
    chk("hold", 24'(counter_hold_out), 24'h000001);
    chk("cp", 24'(cp_tristate_out), 24'h000001);
    send(24'h000100);
    send(24'h000201);
    chk("pd", 24'(powered_down_out), 24'h000000);
    chk("hold", 24'(counter_hold_out), 24'h000001);
    chk("pulses", 24'(pulses), 24'h000002);
    send(24'h000012);
    chk("hold", 24'(counter_hold_out), 24'h000000);
  endtask

  // Raw prescaler toggles every cycle; retiming samples it at one fixed phase
  task automatic t_resync();
    logic v0;
    v0 = prescaler_out;
    @(negedge mclk_in);
    chk("plain", 24'(prescaler_out), 24'(!v0));
    send(24'h200000);
    v0 = prescaler_out;
    repeat (3) begin
      @(negedge mclk_in);
      chk("resync", 24'(prescaler_out), 24'(v0));
    end
    send(24'h600000);
    chk("ref", ref_latch_out, 24'h600000);
    chk("delayed", 24'(prescaler_out), 24'(!v0));
    @(negedge mclk_in);
    chk("delayed", 24'(prescaler_out), 24'(!v0));
  endtask

  initial begin
    repeat (16) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    power_enable_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    t_init();
    t_monitor();
    t_power();
    t_cnt_reset();
    t_resync();
    conclude();
  end
endmodule // synth_latch_power_up_sequencer_test
